// File: src/dct_consts.svh
// constants, timing figures and instruction decodes for the display command interpreter
// Functional notes
// - comparator result offered as skip condition
// - decode device codes 5,6,7 from instruction bits
// - clear-cursor command clears cursor flag
// - vector-mode mode-set clears counter, pass, continue
// - mode-set loads point, absolute, long/short bits
// - load/execute clears ready, starts chosen timer
// - load/execute sets pass from long/short bit
// - data register loads on either load command
// - clear-ready command clears ready flag
// - interrupt while cursor or ready flag set
// - skip when any condition true at pulse one
// - load-data pulse 100 us gates converter
// - axis latch picks x or y transfer
// - ready set at end of load pulse
// - absolute bit closes absolute switch during load
// - execute delay of 20 us
// - delay end: ready in point, strokes in vector
// - each stroke lasts 250 us
// - long vector runs sixteen strokes back to back
// - short vector runs a single stroke
// - output path switch chosen by mode
// - absolute switch only during load data
// - computer start clears cursor and ready flags
// - fifteenth count clears pass, final stroke readies
// - vector continue: delay end readies, no strokes
`ifndef DCT_CONSTS_SVH
`define DCT_CONSTS_SVH
`define DCT_CLK_MHZ        200
`define DCT_LDT_US         100
`define DCT_XDT_US         20
`define DCT_ST_US          250
`define DCT_LDT_CYC        (`DCT_LDT_US * `DCT_CLK_MHZ)
`define DCT_XDT_CYC        (`DCT_XDT_US * `DCT_CLK_MHZ)
`define DCT_ST_CYC         (`DCT_ST_US * `DCT_CLK_MHZ)
`define DCT_STROKES_LONG   16
`define DCT_DEV_CLEAR_CUR  6'o52
`define DCT_DEV_MODE       6'o62
`define DCT_DEV_LOADEX     6'o64
`define DCT_DEV_READY      6'o72
`define DCT_DEV_LOADALT    6'o74
`define DCT_DEV_SKIP_RDY   6'o71
`define DCT_DEV_SKIP_CUR   6'o51
`define DCT_DEV_SKIP_CMP   6'o73
`define DCT_DEV_SKIP_SPR   6'o61
`define DCT_ADDR_CTRL      32'h0000_0000
`define DCT_ADDR_STATUS    32'h0000_0004
`define DCT_ADDR_DATA      32'h0000_0008
`endif

// File: src/dct_pkg.sv
// types shared by the display command interpreter
package dct_pkg;
  typedef enum logic [3:0] {
    DCT_IDLE   = 4'b0001,
    DCT_LOAD   = 4'b0010,
    DCT_XDELAY = 4'b0100,
    DCT_STROKE = 4'b1000
  } dct_state_t;
endpackage

// File: src/dct_ctrl.sv
// command decode, flags, skip/interrupt and timing of the display controller
`timescale 1ns/10ps
`include "dct_consts.svh"

// overview
//   host levels and pulses are taken as
//   synchronous to clk_sys
//   three device groups give five commands
//   load/execute: bit 10 picks the timer
//   delay end: ready, or strokes in vector
//   long vectors: sixteen strokes
//   short vectors: a single stroke
//   vector continue: software sets length

// bit numbering
//   the host word has bit 0 as msb
//   printed bit n sits at index 11-n
//   device field (bits 3..8) is mb[8:3]

// timers
//   one down-counter serves every timer
//   only one timer runs at any time
//   a new load/execute aborts the old one
//   defaults are nominal at 200 MHz
//   small values are for simulation

// limitations
//   no analog behaviour here
//   switches are plain levels
//   bus clears mirror two host commands

module dct_ctrl
  import dct_pkg::*;
#(
  parameter int LDT_CYC = `DCT_LDT_CYC,   // load pulse length in clocks
  parameter int XDT_CYC = `DCT_XDT_CYC,   // execute delay in clocks
  parameter int ST_CYC  = `DCT_ST_CYC     // one stroke in clocks
)(
  input  wire logic        clk_sys,                // 200 MHz clock
  input  wire logic        reset_n,                // async reset, computer start
  input  wire logic [11:0] mb,                     // instruction word, bit 0 msb
  input  wire logic [11:0] ac,                     // accumulator, bit 0 msb
  input  wire logic        iop1,                   // first i/o pulse
  input  wire logic        iop2,                   // second i/o pulse
  input  wire logic        iop4,                   // third i/o pulse
  input  wire logic        cursor_button,          // joystick interrupt button
  input  wire logic        erase_button,           // tube erase button
  input  wire logic        comparator_hi,          // analog comparator result
  input  wire logic        spare_cond,             // spare skip condition
  input  wire logic        hsel,                   // ahb select
  input  wire logic [31:0] haddr,                  // ahb address
  input  wire logic [1:0]  htrans,                 // ahb transfer type
  input  wire logic        hwrite,                 // ahb write
  input  wire logic [2:0]  hsize,                  // ahb size
  input  wire logic [31:0] hwdata,                 // ahb write data
  input  wire logic        hready,                 // ahb bus ready
  output logic      [31:0] hrdata,                 // ahb read data
  output logic             hreadyout,              // ahb slave ready
  output logic             hresp,                  // ahb response, always okay
  output logic             skip_req,               // skip line
  output logic             int_req,                // interrupt line
  output logic [9:0]       data_reg,               // converter data
  output logic             point_output_switch,    // sample-holds to display
  output logic             vector_output_switch,   // integrators to display
  output logic             cursor_output_switch,   // joystick to display
  output logic             absolute_input_switch,  // absolute load path
  output logic             x_transfer_switch,      // load x sample-hold
  output logic             y_transfer_switch,      // load y sample-hold
  output logic             integrator_hold         // hold integrators whenever no stroke is running
);
  // decoded commands
  function automatic logic dev_is(input logic [11:0] w, input logic [5:0] code);
    return w[11:9] == 3'o6 && w[8:3] == code;
  endfunction

  wire logic is_iot = (mb[11:9] == 3'o6);  // opcode, printed bits 0..2
  // instruction bits as printed: bit n is index 11-n
  wire logic mb10 = mb[1];
  wire logic mb11 = mb[0];
  wire logic [5:0] dev_field = mb[8:3];  // bits 3..8 of the printed word
  wire logic grp5 = is_iot && dev_field[5:3] == 3'o5;
  wire logic grp6 = is_iot && dev_field[5:3] == 3'o6;
  wire logic grp7 = is_iot && dev_field[5:3] == 3'o7;
  wire logic cmd_clear_cursor_flag = grp5 && dev_field[2:0] == 3'o0 && iop2;
  wire logic cmd_mode_set          = grp6 && dev_field[2:0] == 3'o0 && iop2;
  wire logic cmd_load_execute      = grp6 && dev_field[2:0] == 3'o0 && iop4;
  wire logic cmd_clear_ready       = grp7 && dev_field[2:0] == 3'o0 && iop2;
  wire logic cmd_data_load_alt     = grp7 && dev_field[2:0] == 3'o0 && iop4;

  // software commands via ahb mirror the pulses
  logic        sw_clear_cur, sw_clear_rdy;    // write-one strobes
  // mode bits
  logic point_path_bit_r, absolute_bit_r, long_vec_r;   // path bits
  logic cursor_mode_r;                                  // cursor display select
  logic cursor_flag_r, ready_flag_r, pass_r, vector_continue_r;
  logic axis_select_latch_r;                            // x/y choice
  logic [4:0] stroke_cnt_r;                             // divide-by-16 counter
  logic [31:0] tmr_r;                                   // shared timer
  dct_state_t st_r;                                     // timing state

  wire logic tmr_done = (tmr_r == 32'h0000_0001);
  // any load command clocks the data register
  wire logic data_clk = cmd_load_execute | cmd_data_load_alt;
  wire logic vec_mode = ~point_path_bit_r;
  wire logic ldt_end  = st_r == DCT_LOAD && tmr_done;
  wire logic xdt_end  = st_r == DCT_XDELAY && tmr_done;
  wire logic st_end   = st_r == DCT_STROKE && tmr_done;
  wire logic last_stroke = (stroke_cnt_r == 5'(`DCT_STROKES_LONG - 1));
  // ready set sources
  wire logic rdy_set = ldt_end
                     | (xdt_end & (~vec_mode | vector_continue_r))
                     | (st_end & ~pass_r)
                     | erase_button;
  wire logic rdy_clr = cmd_clear_ready | cmd_load_execute | sw_clear_rdy;
  wire logic cur_clr = cmd_clear_cursor_flag | sw_clear_cur;

  // state walk
  //   idle: nothing timing
  //   load: converter gated into a
  //   sample-hold; ready at its end
  //   xdelay: settle time before strokes
  //   stroke: one stroke per reload

  // hazard
  //   tmr_done means one left, so a
  //   count of n gives n cycles in state
  //   the counter rests at zero after reset, at one after a timer;
  //   every use is qualified by state

  // timing state machine; one counter serves every timer
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r  <= DCT_IDLE;
      tmr_r <= 32'h0000_0000;
    end
    else if (cmd_load_execute)
    begin
      // restart: a new load/execute aborts any operation in progress
      st_r  <= mb10 ? DCT_XDELAY : DCT_LOAD;
      tmr_r <= mb10 ? 32'(XDT_CYC) : 32'(LDT_CYC);
    end
    else
    begin
      case (st_r)
        DCT_LOAD:
          if (tmr_done) st_r <= DCT_IDLE; else tmr_r <= tmr_r - 32'h0000_0001;
        DCT_XDELAY:
          if (tmr_done)
          begin
            if (vec_mode && !vector_continue_r)
            begin
              st_r  <= DCT_STROKE;
              tmr_r <= 32'(ST_CYC);
            end
            else st_r <= DCT_IDLE;
          end
          else tmr_r <= tmr_r - 32'h0000_0001;
        DCT_STROKE:
          if (tmr_done)
          begin
            if (pass_r) tmr_r <= 32'(ST_CYC);
            else st_r <= DCT_IDLE;
          end
          else tmr_r <= tmr_r - 32'h0000_0001;
        default: st_r <= DCT_IDLE;
      endcase
    end
  end

  // pass and counter
  //   pass set: more strokes follow
  //   pass clear: this stroke is final
  //   pass drops one stroke early so the
  //   sixteenth stroke ends with it clear

  // stroke counter and pass flag
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pass_r       <= 1'b0;
      stroke_cnt_r <= 5'h00;
    end
    else if (cmd_mode_set && vec_mode)
    begin
      pass_r       <= 1'b0;
      stroke_cnt_r <= 5'h00;
    end
    else if (cmd_load_execute)
    begin
      pass_r       <= long_vec_r;
      stroke_cnt_r <= 5'h00;
    end
    else if (st_end && pass_r)
    begin
      // fifteenth count drops pass so the next stroke is final
      stroke_cnt_r <= stroke_cnt_r + 5'h01;
      if (stroke_cnt_r == 5'(`DCT_STROKES_LONG - 2)) pass_r <= 1'b0;
    end
  end

  // mode bits
  //   point, cursor, long from the
  //   accumulator; absolute from bit 10
  //   of the instruction word itself

  // mode register, latched from the accumulator and instruction bit 10
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      point_path_bit_r  <= 1'b1;
      absolute_bit_r    <= 1'b0;
      long_vec_r        <= 1'b0;
      cursor_mode_r     <= 1'b0;
      vector_continue_r <= 1'b0;
    end
    else
    begin
      if (cmd_mode_set)
      begin
        point_path_bit_r <= ac[11-2];
        absolute_bit_r   <= mb10;
        long_vec_r       <= ac[11-4];
        cursor_mode_r    <= ac[11-3];
      end
      if (cmd_mode_set && vec_mode) vector_continue_r <= 1'b0;
      else if (cmd_load_execute && mb10) vector_continue_r <= ac[11-7];
    end
  end

  // data register
  //   either load command clocks it
  //   axis latch keeps bit 11 so the
  //   word may change during the load

  // data register and axis latch
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_reg            <= 10'h000;
      axis_select_latch_r <= 1'b0;
    end
    else
    begin
      if (data_clk) data_reg <= ac[9:0];
      if (cmd_load_execute) axis_select_latch_r <= mb11;
    end
  end

  // flags
  //   buttons are levels: a held button
  //   keeps its flag set over a clear
  //   trade-off: no edge detect, so no
  //   false edge after start

  // flags; a set in the cycle of a clear wins
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cursor_flag_r <= 1'b0;
      ready_flag_r  <= 1'b0;
    end
    else
    begin
      cursor_flag_r <= cursor_button | (cursor_flag_r & ~cur_clr);
      ready_flag_r  <= rdy_set | (ready_flag_r & ~rdy_clr);
    end
  end

  // skip sources, each with its own decode
  wire logic skip_any = iop1 & (
      (dev_is(mb, `DCT_DEV_SKIP_RDY) & ready_flag_r)
    | (dev_is(mb, `DCT_DEV_SKIP_CUR) & cursor_flag_r)
    | (dev_is(mb, `DCT_DEV_SKIP_CMP) & comparator_hi)
    | (dev_is(mb, `DCT_DEV_SKIP_SPR) & spare_cond));
  wire logic load_pulse = st_r == DCT_LOAD;

  // outputs
  //   all registered, one edge behind
  //   the state that drives them
  //   interrupt uses next flag values so
  //   it rises with the flag, not after
  //   skip stands one cycle per pulse

  // registered analog switch drives and bus lines
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      skip_req              <= 1'b0;
      int_req               <= 1'b0;
      point_output_switch   <= 1'b0;
      vector_output_switch  <= 1'b0;
      cursor_output_switch  <= 1'b0;
      absolute_input_switch <= 1'b0;
      x_transfer_switch     <= 1'b0;
      y_transfer_switch     <= 1'b0;
      integrator_hold       <= 1'b1;
    end
    else
    begin
      skip_req              <= skip_any;
      int_req               <= rdy_set | cursor_button
                             | (cursor_flag_r & ~cur_clr) | (ready_flag_r & ~rdy_clr);
      // exactly one output path closed
      point_output_switch   <= ~cursor_mode_r & point_path_bit_r;
      vector_output_switch  <= ~cursor_mode_r & ~point_path_bit_r;
      cursor_output_switch  <= cursor_mode_r;
      absolute_input_switch <= load_pulse & absolute_bit_r;
      x_transfer_switch     <= load_pulse & ~axis_select_latch_r;
      y_transfer_switch     <= load_pulse & axis_select_latch_r;
      integrator_hold       <= st_r != DCT_STROKE;
    end
  end

  // bus map
  //   ctrl write: bit 0 clears ready,
  //   bit 1 clears cursor
  //   status read: state, mode, flags
  //   data read: the data register
  //   others read zero
  //   read data is registered at the
  //   address phase, held in data phase

  // ahb-lite slave: zero wait states, okay always
  logic        ap_valid_r, ap_write_r;
  logic [31:0] ap_addr_r;
  wire  logic  ap_take = hsel & htrans[1] & hready;
  wire  logic  wr_ctrl = ap_valid_r & ap_write_r & (ap_addr_r == `DCT_ADDR_CTRL);
  assign sw_clear_rdy = wr_ctrl & hwdata[0];
  assign sw_clear_cur = wr_ctrl & hwdata[1];
  wire logic [31:0] rd_mux =
      (haddr == `DCT_ADDR_STATUS) ? {22'h00_0000, st_r, cursor_mode_r, long_vec_r,
                                     absolute_bit_r, point_path_bit_r, cursor_flag_r, ready_flag_r}
    : (haddr == `DCT_ADDR_DATA)   ? {22'h00_0000, data_reg}
    : 32'h0000_0000;
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r  <= 32'h0000_0000;
      hrdata     <= 32'h0000_0000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
    else
    begin
      ap_valid_r <= ap_take;
      ap_write_r <= hwrite;
      ap_addr_r  <= haddr;
      hrdata     <= (ap_take & ~hwrite) ? rd_mux : 32'h0000_0000;
    end
  end
endmodule

// File: tb/dct_ctrl_sva.sv
// port-level assertions for the display command interpreter
`timescale 1ns/10ps
module dct_ctrl_chk #(
  parameter int LDT_CYC = 20  // load pulse length in clocks
)(
  input wire logic        clk_sys,                // clock
  input wire logic        reset_n,                // async reset
  input wire logic [11:0] mb,                     // instruction word
  input wire logic        iop1,                   // first pulse
  input wire logic        iop4,                   // third pulse
  input wire logic        cursor_button,          // joystick button
  input wire logic        comparator_hi,          // comparator result
  input wire logic        skip_req,               // skip line
  input wire logic        int_req,                // interrupt line
  input wire logic        point_output_switch,    // point path
  input wire logic        vector_output_switch,   // vector path
  input wire logic        cursor_output_switch,   // cursor path
  input wire logic        absolute_input_switch,  // absolute input
  input wire logic        x_transfer_switch,      // x load
  input wire logic        y_transfer_switch       // y load
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic [15:0] ld_cnt_r;    // cycles the load switch has been closed
  logic [15:0] ld_cnt_nxt;  // next count
  wire ld_on = x_transfer_switch || y_transfer_switch;           // any load switch
  wire ld_go = iop4 && (mb[8:3] == 6'h30) && !mb[1];             // load command taken
  assign ld_cnt_nxt = ld_on ? ld_cnt_r + 16'h0001 : 16'h0000;
  // counter keeps the pulse width check free of long repetitions
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
      ld_cnt_r <= 16'h0000;
    else
      ld_cnt_r <= ld_cnt_nxt;
  xy_exclusive_a: assert property (!(x_transfer_switch && y_transfer_switch)) else $error("both axes loading");
  abs_in_load_a: assert property (absolute_input_switch |-> ld_on) else $error("absolute switch outside load");
  path_onehot_a: assert property ($onehot0({point_output_switch, vector_output_switch, cursor_output_switch}))
    else $error("two output paths closed");
  load_width_a: assert property ($fell(ld_on) |-> ld_cnt_r == LDT_CYC) else $error("load pulse width wrong");
  load_start_a: assert property (ld_go |-> ##[1:3] ld_on) else $error("load pulse not started");
  load_axis_a: assert property (ld_go && mb[0] |-> ##[1:3] y_transfer_switch) else $error("wrong axis loaded");
  cursor_irq_a: assert property (cursor_button |-> ##[1:2] int_req) else $error("no interrupt on cursor");
  skip_cmp_a: assert property (iop1 && mb[8:3] == 6'h3b && comparator_hi |=> skip_req)
    else $error("comparator skip missing");
  skip_cause_a: assert property (skip_req |-> $past(iop1)) else $error("skip without pulse one");
  start_clear_a: assert property ($rose(reset_n) |-> !int_req && !skip_req) else $error("flags set at start");
  cover property (ld_on && absolute_input_switch);
  cover property (vector_output_switch && int_req);
  cover property (skip_req);
endmodule
bind dct_ctrl dct_ctrl_chk #(.LDT_CYC(LDT_CYC)) u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .mb(mb), .iop1(iop1),
  .iop4(iop4), .cursor_button(cursor_button), .comparator_hi(comparator_hi), .skip_req(skip_req), .int_req(int_req),
  .point_output_switch(point_output_switch), .vector_output_switch(vector_output_switch),
  .cursor_output_switch(cursor_output_switch), .absolute_input_switch(absolute_input_switch),
  .x_transfer_switch(x_transfer_switch), .y_transfer_switch(y_transfer_switch));

// File: tb/dct_host_model.sv
// host programmed-i/o bus model issuing instructions and pulses
`timescale 1ns/10ps
module dct_host_model (
  input wire logic        clk_sys,   // clock
  input wire logic        skip_req,  // skip line from device
  output logic     [11:0] mb,        // instruction word
  output logic     [11:0] ac,        // accumulator
  output logic            iop1,      // first pulse
  output logic            iop2,      // second pulse
  output logic            iop4       // third pulse
);
  initial
  begin
    mb = 12'h000;
    ac = 12'h000;
    iop1 = 1'b0;
    iop2 = 1'b0;
    iop4 = 1'b0;
  end
  // one instruction: levels and one pulse for a cycle, then levels scrambled
  task automatic iot(input logic [5:0] dev, input logic [1:0] lo, input logic [11:0] acv, input int p);
    @(posedge clk_sys);
    mb <= {3'h6, dev, 1'b0, lo};
    ac <= acv;
    iop1 <= (p == 1);
    iop2 <= (p == 2);
    iop4 <= (p == 4);
    @(posedge clk_sys);
    iop1 <= 1'b0;
    iop2 <= 1'b0;
    iop4 <= 1'b0;
    mb <= ~mb;  // stale levels must not be reused by the device
    ac <= ~ac;
  endtask
  // software conversion loop: trial bit kept when the comparator skips
  task automatic sar(output logic [9:0] v);
    logic [9:0] t;
    v = 10'h000;
    for (int i = 9; i >= 0; i--)
    begin
      t = v | (10'h001 << i);
      iot(6'h38, 2'b00, {2'b00, t}, 4);
      iot(6'h3b, 2'b00, 12'h000, 1);
      @(negedge clk_sys);
      if (skip_req === 1'b1)
        v = t;
    end
  endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench for the display command interpreter
`timescale 1ns/10ps
module tb_top;
  localparam int LOAD_DATA_TIMER = 20;  // shortened load pulse
  localparam int EXECUTE_DELAY_TIMER = 8;   // shortened execute delay
  localparam int STK = 30;  // shortened stroke
  localparam logic [31:0] m_skip = 32'h0004_0000, m_int = 32'h0002_0000, m_pm = 32'h0001_0000;
  localparam logic [31:0] m_vm = 32'h0000_8000, m_cm = 32'h0000_4000, m_abs = 32'h0000_2000;
  localparam logic [31:0] m_x = 32'h0000_1000, m_y = 32'h0000_0800, m_d = 32'h0000_03ff;
  localparam logic [11:0] mode_ac [4] = '{12'h200, 12'h000, 12'h080, 12'h000};  // point, short, long, short
  localparam logic [11:0] exe_ac [4] = '{12'h000, 12'h000, 12'h000, 12'h010};   // last: vector continue
  localparam logic [31:0] path_exp [4] = '{m_pm, m_vm, m_vm, m_vm};
  localparam int lat [4] = '{EXECUTE_DELAY_TIMER, EXECUTE_DELAY_TIMER + STK, EXECUTE_DELAY_TIMER + 16 * STK, EXECUTE_DELAY_TIMER};
  typedef struct {string nm; logic [31:0] e; logic [31:0] m; bit bus;} dct_note_t;
  logic        clk_sys, reset_n, cursor_button, erase_button, spare_cond, hsel, hwrite, look;
  logic        iop1, iop2, iop4, hreadyout, hresp, skip_req, int_req, pm, vm, cm, absw, xs, ys, ih;
  logic [11:0] mb, ac;
  logic [31:0] haddr, hwdata, hrdata, rd_v, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [9:0]  data_reg, secret, got;
  logic [15:0] lfsr_r;
  int          mismatches, checked, cyc, n;
  dct_note_t   notes[$];
  wire [18:0] obs = {skip_req, int_req, pm, vm, cm, absw, xs, ys, ih, data_reg};  // watched outputs
  wire        hready = hreadyout;                                                // single slave
  wire        comparator_hi = (data_reg <= secret);                              // analog compare model
  dct_ctrl #(.LDT_CYC(LOAD_DATA_TIMER), .XDT_CYC(EXECUTE_DELAY_TIMER), .ST_CYC(STK)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .mb(mb),
    .ac(ac), .iop1(iop1), .iop2(iop2), .iop4(iop4), .cursor_button(cursor_button), .erase_button(erase_button),
    .comparator_hi(comparator_hi), .spare_cond(spare_cond), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .skip_req(skip_req), .int_req(int_req), .data_reg(data_reg), .point_output_switch(pm),
    .vector_output_switch(vm), .cursor_output_switch(cm), .absolute_input_switch(absw),
    .x_transfer_switch(xs), .y_transfer_switch(ys), .integrator_hold(ih));
  dct_host_model host (.clk_sys(clk_sys), .skip_req(skip_req), .mb(mb), .ac(ac), .iop1(iop1), .iop2(iop2),
    .iop4(iop4));
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] lfsr_nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // note an expectation; the watcher compares at the next falling edge
  task lk(input string nm, input logic [31:0] e, input logic [31:0] m, input bit bus);
    notes.push_back('{nm, e, m, bus});
    look <= 1'b1;
    tick(1);
    look <= 1'b0;
    tick(1);
  endtask
  // single ahb-lite transfer, read data kept in rd_v
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'b010;
    do tick(1); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do tick(1); while (hreadyout !== 1'b1);
    rd_v = hrdata;
  endtask
  task bump_ready;
    erase_button <= 1'b1;
    tick(1);
    erase_button <= 1'b0;
    tick(2);
  endtask
  // count cycles until the interrupt, bounded
  task wait_int;
    n = 4;
    while (int_req !== 1'b1 && n < 2000)
    begin
      tick(1);
      n++;
    end
  endtask
  // watcher: oldest note against what the outputs show
  always @(negedge clk_sys)
    if (look === 1'b1)
    begin
      dct_note_t t;
      t = notes.pop_front();
      check(t.nm, (t.bus ? rd_v : {13'h0000, obs}) & t.m, t.e & t.m);
    end
  // hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      mismatches++;
      print_verdict;
    end
  end
  initial
  begin
    {reset_n, cursor_button, erase_button, spare_cond, hsel, hwrite, look} = 7'h00;
    {haddr, hwdata, htrans, hsize} = 69'h0;
    secret = 10'h000;
    lfsr_r = 16'h0011;
    tick(5);
    reset_n <= 1'b1;
    tick(2);
    lk("after start", m_pm, m_skip | m_int | m_pm, 0);
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    lk("status idle", 32'h0000_0000, 32'h0000_0003, 1);
    lfsr_r = lfsr_nxt(lfsr_r);
    ahb(1'b0, {22'h00_0000, lfsr_r[7:0], 2'b00} | 32'h0000_0100, 32'h0000_0000);
    lk("unmapped read", 32'h0000_0000, 32'hffff_ffff, 1);
    cursor_button <= 1'b1;
    tick(1);
    cursor_button <= 1'b0;
    tick(2);
    lk("cursor int", m_int, m_int, 0);
    host.iot(6'h29, 2'b00, 12'h000, 1);
    lk("skip cursor", m_skip, m_skip, 0);
    host.iot(6'h28, 2'b00, 12'h000, 2);
    tick(2);
    lk("cursor cleared", 32'h0000_0000, m_int | m_skip, 0);
    host.iot(6'h29, 2'b00, 12'h000, 1);
    lk("no cursor skip", 32'h0000_0000, m_skip, 0);
    bump_ready;
    host.iot(6'h39, 2'b00, 12'h000, 1);
    lk("skip ready", m_skip | m_int, m_skip | m_int, 0);
    host.iot(6'h38, 2'b00, 12'h000, 2);
    tick(2);
    lk("ready cleared", 32'h0000_0000, m_int, 0);
    bump_ready;
    ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
    tick(2);
    lk("bus clears ready", 32'h0000_0000, m_int, 0);
    spare_cond <= 1'b1;
    host.iot(6'h31, 2'b00, 12'h000, 1);
    lk("skip spare", m_skip, m_skip, 0);
    spare_cond <= 1'b0;
    host.iot(6'h30, 2'b10, 12'h200, 2);
    bump_ready;
    lfsr_r = lfsr_nxt(lfsr_r);
    v = {22'h00_0000, lfsr_r[9:0]};
    host.iot(6'h30, 2'b01, v[11:0], 4);
    tick(2);
    lk("load y", m_abs | m_y | v, m_int | m_abs | m_x | m_y | m_d, 0);
    wait_int;
    check("load time", (n >= LOAD_DATA_TIMER && n <= LOAD_DATA_TIMER + 6), 32'h0000_0001);
    lfsr_r = lfsr_nxt(lfsr_r);
    host.iot(6'h38, 2'b00, {2'b00, lfsr_r[9:0]}, 4);
    lk("alt load", {22'h00_0000, lfsr_r[9:0]}, m_d, 0);
    for (int k = 0; k < 4; k++)
    begin
      bump_ready;
      host.iot(6'h30, 2'b00, mode_ac[k], 2);
      host.iot(6'h30, 2'b10, exe_ac[k], 4);
      tick(2);
      lk("exec path", path_exp[k], m_int | m_pm | m_vm | m_x | m_y, 0);
      wait_int;
      check("exec time", (n >= lat[k] && n <= lat[k] + 20), 32'h0000_0001);
    end
    host.iot(6'h30, 2'b00, 12'h100, 2);
    tick(1);
    lk("cursor path", m_cm, m_pm | m_vm | m_cm, 0);
    lfsr_r = lfsr_nxt(lfsr_r);
    secret <= lfsr_r[9:0];
    host.sar(got);
    check("conversion", {22'h00_0000, got}, {22'h00_0000, secret});
    print_verdict;
  end
endmodule
